// [rtl/mem_mode_pkg.sv]
// package: strap codes, overlay decode, select and register map constants
package mem_mode_pkg;

    // ************************************************
    // register map (byte addresses)
    // ************************************************
    localparam int AXI_ADDR_W = 8;
    localparam logic [7:0] OFS_OVERLAY = 8'h00;
    localparam logic [7:0] OFS_IO_WAIT = 8'h04;
    localparam logic [7:0] OFS_SEL_EN = 8'h08;
    localparam logic [7:0] OFS_SYS_CTRL = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h14;

    // ************************************************
    // field positions
    // ************************************************
    localparam int OVL_PROG_LSB = 0;
    localparam int OVL_DATA_LSB = 4;
    localparam int OVL_DATA_WAIT_SETTING_LSB = 8;
    localparam int IOWAIT_STRIDE = 4;
    localparam int SYS_BSD_BIT = 3;
    localparam int FLAG_OUT_BIT = 0;
    localparam int FLAG_DIR_BIT = 1;
    localparam int ST_STRAP_LSB = 0;
    localparam int ST_HOST_BIT = 4;
    localparam int ST_RUN_BIT = 5;
    localparam int ST_EXT_BIT = 6;
    localparam int ST_FLAG_BIT = 7;
    localparam int ST_BCNT_LSB = 8;
    localparam int MODE_C_BIT = 2;

    // ************************************************
    // reset values
    // ************************************************
    localparam logic [3:0] SEL_EN_RESET = 4'hB;
    localparam logic [2:0] DATA_WAIT_SETTING_RESET = 3'h7;
    localparam logic [11:0] IOWAIT_RESET = 12'hFFF;

    // ************************************************
    // strap codes {mode c, mode b, mode a}, boot length
    // ************************************************
    localparam logic [2:0] STRAP_BYTE_FULL = 3'h0;
    localparam logic [2:0] STRAP_NO_BOOT = 3'h2;
    localparam logic [2:0] STRAP_BYTE_HOST = 3'h4;
    localparam logic [2:0] STRAP_HOST_DMA = 3'h5;
    localparam logic [5:0] BOOT_WORDS = 6'h20;

    // ************************************************
    // overlays, spaces, selects, responses
    // ************************************************
    localparam logic [1:0] OVL_EXT1 = 2'h1;
    localparam logic [1:0] OVL_EXT2 = 2'h2;
    localparam logic [13:0] OVL_BASE = 14'h2000;
    localparam int IO_ADDR_W = 11;
    localparam int IO_REGION_LSB = 9;
    localparam logic [1:0] SPACE_PROG = 2'h0;
    localparam logic [1:0] SPACE_DATA = 2'h1;
    localparam logic [1:0] SPACE_IO = 2'h2;
    localparam logic [1:0] SPACE_BOOT = 2'h3;
    localparam int SEL_BOOT = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ACC_IDLE, ACC_EXT, ACC_DONE} acc_state_t;
    typedef enum logic [1:0] {BOOT_RELEASE, BOOT_BYTE_WAIT, BOOT_HOST_WAIT, BOOT_RUN} boot_state_t;

endpackage : mem_mode_pkg

// [rtl/mem_mode_decode.sv]
// memory mode straps, boot control, overlay/io decode, composite select
`timescale 1ns/10ps

module mem_mode_decode
    import mem_mode_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // straps and shared flag pin
    input wire logic mode_a_strap,
    input wire logic mode_b_strap,
    input wire logic flag_two_in,
    output logic flag_two_out,
    output logic flag_two_oe,
    // boot handshake
    input wire logic boot_word_loaded,
    input wire logic host_pm0_written,
    output logic boot_dma_start,
    output logic core_run,
    output logic exec_external,
    // core access path
    input wire logic acc_req,
    input wire logic [1:0] acc_space,
    input wire logic acc_fetch,
    input wire logic [13:0] acc_addr,
    output logic acc_done,
    output logic acc_error,
    // external bus
    input wire logic bus_req,
    output logic bus_grant,
    output logic [13:0] ext_addr,
    output logic program_memory_select_n,
    output logic data_memory_select_n,
    output logic boot_memory_select_n,
    output logic io_space_select_n,
    output logic composite_select_n,
    // axi4-lite write
    input wire logic [AXI_ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [AXI_ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        acc_state_t acc;
        boot_state_t boot;
        logic [2:0] strap;
        logic [1:0] povl;
        logic [1:0] dovl;
        logic [2:0] data_wait_setting;
        logic [11:0] iowait;
        logic [3:0] cs_en;
        logic bsd;
        logic fl_out;
        logic fl_dir;
        logic fl_oe;
        logic [2:0] wcnt;
        logic [13:0] ext_addr;
        logic [3:0] sel_n;
        logic bms_n;
        logic cms_n;
        logic done;
        logic err;
        logic run;
        logic exec_ext;
        logic boot_go;
        logic [5:0] bcnt;
        logic grant;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } state_t;

    state_t s_reg;
    state_t s_next;
    logic take_int;
    logic take_ext;
    logic [2:0] pick_wait;
    logic ext_hit;
    logic refuse;
    logic [31:0] img_ovl;
    logic [31:0] img_iow;
    logic [31:0] img_sel;
    logic [31:0] img_sys;
    logic [31:0] img_st;
    logic [31:0] img_flag;
    logic [31:0] wv;

    // ************************************************
    // functions
    // ************************************************
    // overlay window hit: selector 1 or 2 and upper half
    function automatic logic ovl_hit(input logic [1:0] ovl, input logic [13:0] a);
        ovl_hit = (ovl == OVL_EXT1 || ovl == OVL_EXT2) && a >= OVL_BASE;
    endfunction : ovl_hit

    // select bit of a space, in the bit order of the composite select enables
    function automatic logic [1:0] sel_bit(input logic [1:0] sp);
        unique case (sp)
            SPACE_IO: sel_bit = 2'(SEL_BOOT + 1);
            SPACE_BOOT: sel_bit = 2'(SEL_BOOT);
            default: sel_bit = sp;
        endcase
    endfunction : sel_bit

    // byte lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction : merge

    // ************************************************
    // register images
    // ************************************************
    assign img_ovl = (32'(s_reg.povl) << OVL_PROG_LSB) | (32'(s_reg.dovl) << OVL_DATA_LSB)
                   | (32'(s_reg.data_wait_setting) << OVL_DATA_WAIT_SETTING_LSB);
    always_comb begin
        img_iow = '0;
        for (int i = 0; i < 4; i++) begin
            img_iow[i*IOWAIT_STRIDE +: 3] = s_reg.iowait[i*3 +: 3];
        end
    end
    assign img_sel = 32'(s_reg.cs_en);
    assign img_sys = 32'(s_reg.bsd) << SYS_BSD_BIT;
    assign img_flag = (32'(s_reg.fl_out) << FLAG_OUT_BIT) | (32'(s_reg.fl_dir) << FLAG_DIR_BIT);
    assign img_st = (32'(s_reg.strap) << ST_STRAP_LSB) | (32'(s_reg.strap[MODE_C_BIT]) << ST_HOST_BIT)
                  | (32'(s_reg.run) << ST_RUN_BIT) | (32'(s_reg.exec_ext) << ST_EXT_BIT)
                  | (32'(flag_two_in) << ST_FLAG_BIT) | (32'(s_reg.bcnt) << ST_BCNT_LSB);

    // ************************************************
    // next state
    // ************************************************
    always_comb begin
        s_next = s_reg;
        wv = '0;
        take_int = 1'b0;
        take_ext = 1'b0;
        s_next.done = 1'b0;
        s_next.err = 1'b0;
        s_next.boot_go = 1'b0;

        // access decode: overlays, io space, boot space
        unique case (acc_space)
            SPACE_PROG: ext_hit = ovl_hit(s_reg.povl, acc_addr);
            SPACE_DATA: ext_hit = ovl_hit(s_reg.dovl, acc_addr);
            default: ext_hit = 1'b1;
        endcase
        unique case (acc_space)
            SPACE_IO: pick_wait = s_reg.iowait[acc_addr[IO_REGION_LSB +: 2]*3 +: 3];
            SPACE_BOOT: pick_wait = '0;
            default: pick_wait = s_reg.data_wait_setting;
        endcase
        refuse = s_reg.strap[MODE_C_BIT] && acc_fetch && acc_space == SPACE_PROG && ext_hit;

        // access sequencer
        unique case (s_reg.acc)
            ACC_IDLE: begin
                if (acc_req && (!ext_hit || refuse)) begin
                    s_next.acc = ACC_DONE;
                    s_next.done = 1'b1;
                    s_next.err = refuse;
                    take_int = !refuse;
                end else if (acc_req && !bus_req) begin
                    s_next.acc = ACC_EXT;
                    s_next.wcnt = pick_wait;
                    take_ext = 1'b1;
                    s_next.sel_n[sel_bit(acc_space)] = 1'b0;
                    if (s_reg.strap[MODE_C_BIT]) begin
                        s_next.ext_addr = {13'h0000, acc_addr[0]};
                    end else if (acc_space == SPACE_IO) begin
                        s_next.ext_addr = {3'h0, acc_addr[IO_ADDR_W-1:0]};
                    end else if (acc_space == SPACE_BOOT) begin
                        s_next.ext_addr = acc_addr;
                    end else begin
                        s_next.ext_addr = {(acc_space == SPACE_PROG ? s_reg.povl : s_reg.dovl) == OVL_EXT2,
                                           acc_addr[12:0]};
                    end
                end
            end
            ACC_EXT: begin
                if (s_reg.wcnt == 3'h0) begin
                    s_next.acc = ACC_DONE;
                    s_next.done = 1'b1;
                    s_next.sel_n = 4'hF;
                end else begin
                    s_next.wcnt = s_reg.wcnt - 3'h1;
                end
            end
            ACC_DONE: s_next.acc = ACC_IDLE;
            default: s_next.acc = ACC_IDLE;
        endcase
        s_next.bms_n = s_next.sel_n[SEL_BOOT] | s_next.bsd;
        s_next.cms_n = ~|(~s_next.sel_n & s_next.cs_en);
        s_next.grant = bus_req && s_next.acc != ACC_EXT;

        // boot control after release
        unique case (s_reg.boot)
            BOOT_RELEASE: begin
                if (!bus_req) begin
                    if (s_reg.strap == STRAP_BYTE_FULL || s_reg.strap == STRAP_BYTE_HOST) begin
                        s_next.boot = BOOT_BYTE_WAIT;
                        s_next.boot_go = 1'b1;
                    end else if (s_reg.strap == STRAP_HOST_DMA) begin
                        s_next.boot = BOOT_HOST_WAIT;
                    end else begin
                        s_next.boot = BOOT_RUN;
                        s_next.run = 1'b1;
                        s_next.exec_ext = s_reg.strap == STRAP_NO_BOOT;
                    end
                end
            end
            BOOT_BYTE_WAIT: begin
                if (boot_word_loaded) begin
                    s_next.bcnt = s_reg.bcnt + 6'h01;
                    if (s_reg.bcnt == BOOT_WORDS - 6'h01) begin
                        s_next.boot = BOOT_RUN;
                        s_next.run = 1'b1;
                    end
                end
            end
            BOOT_HOST_WAIT: begin
                if (host_pm0_written) begin
                    s_next.boot = BOOT_RUN;
                    s_next.run = 1'b1;
                end
            end
            BOOT_RUN: s_next.run = 1'b1;
        endcase

        // flag pin driven only by software direction
        s_next.fl_oe = s_reg.fl_dir;

        // axi write channels, either order
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (awvalid && s_reg.awready) begin
            s_next.aw_got = 1'b1;
            s_next.aw_addr = awaddr;
        end
        if (wvalid && s_reg.wready) begin
            s_next.w_got = 1'b1;
            s_next.w_data = wdata;
            s_next.w_strb = wstrb;
        end
        if (s_next.aw_got && s_next.w_got && !s_reg.bvalid) begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            unique case (s_next.aw_addr)
                OFS_OVERLAY: begin
                    wv = merge(img_ovl, s_next.w_data, s_next.w_strb);
                    s_next.povl = wv[OVL_PROG_LSB +: 2];
                    s_next.dovl = wv[OVL_DATA_LSB +: 2];
                    s_next.data_wait_setting = wv[OVL_DATA_WAIT_SETTING_LSB +: 3];
                end
                OFS_IO_WAIT: begin
                    wv = merge(img_iow, s_next.w_data, s_next.w_strb);
                    for (int i = 0; i < 4; i++) begin
                        s_next.iowait[i*3 +: 3] = wv[i*IOWAIT_STRIDE +: 3];
                    end
                end
                OFS_SEL_EN: begin
                    wv = merge(img_sel, s_next.w_data, s_next.w_strb);
                    s_next.cs_en = wv[3:0];
                end
                OFS_SYS_CTRL: begin
                    wv = merge(img_sys, s_next.w_data, s_next.w_strb);
                    s_next.bsd = wv[SYS_BSD_BIT];
                end
                OFS_FLAG: begin
                    wv = merge(img_flag, s_next.w_data, s_next.w_strb);
                    s_next.fl_out = wv[FLAG_OUT_BIT];
                    s_next.fl_dir = wv[FLAG_DIR_BIT];
                end
                OFS_STATUS: ; // read only, write ignored
                default: s_next.bresp = RESP_SLVERR;
            endcase
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready = !s_next.w_got && !s_next.bvalid;

        // axi read channel
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (arvalid && s_reg.arready) begin
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            unique case (araddr)
                OFS_OVERLAY: s_next.rdata = img_ovl;
                OFS_IO_WAIT: s_next.rdata = img_iow;
                OFS_SEL_EN: s_next.rdata = img_sel;
                OFS_SYS_CTRL: s_next.rdata = img_sys;
                OFS_STATUS: s_next.rdata = img_st;
                OFS_FLAG: s_next.rdata = img_flag;
                default: begin
                    s_next.rdata = '0;
                    s_next.rresp = RESP_SLVERR;
                end
            endcase
        end
        s_next.arready = !s_next.rvalid;

        // reset: constants, straps keep following the pins
        if (!reset_n) begin
            s_next = '0;
            s_next.acc = ACC_IDLE;
            s_next.boot = BOOT_RELEASE;
            s_next.strap = {flag_two_in, mode_b_strap, mode_a_strap};
            s_next.data_wait_setting = DATA_WAIT_SETTING_RESET;
            s_next.iowait = IOWAIT_RESET;
            s_next.cs_en = SEL_EN_RESET;
            s_next.sel_n = 4'hF;
            s_next.bms_n = 1'b1;
            s_next.cms_n = 1'b1;
        end
    end

    // register the whole state
    always_ff @(posedge core_clk) begin
        s_reg <= s_next;
    end

    // ************************************************
    // outputs
    // ************************************************
    assign flag_two_out = s_reg.fl_out;
    assign flag_two_oe = s_reg.fl_oe;
    assign boot_dma_start = s_reg.boot_go;
    assign core_run = s_reg.run;
    assign exec_external = s_reg.exec_ext;
    assign acc_done = s_reg.done;
    assign acc_error = s_reg.err;
    assign bus_grant = s_reg.grant;
    assign ext_addr = s_reg.ext_addr;
    assign program_memory_select_n = s_reg.sel_n[SPACE_PROG];
    assign data_memory_select_n = s_reg.sel_n[SPACE_DATA];
    assign io_space_select_n = s_reg.sel_n[sel_bit(SPACE_IO)];
    assign boot_memory_select_n = s_reg.bms_n;
    assign composite_select_n = s_reg.cms_n;
    assign awready = s_reg.awready;
    assign wready = s_reg.wready;
    assign bvalid = s_reg.bvalid;
    assign bresp = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid = s_reg.rvalid;
    assign rdata = s_reg.rdata;
    assign rresp = s_reg.rresp;

    // ************************************************
    // assertions
    // ************************************************
    property p_strap_hold;
        @(posedge core_clk) disable iff (!reset_n)
        $past(reset_n) |-> $stable(s_reg.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed after reset");

    property p_byte_hold;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.boot == BOOT_BYTE_WAIT |-> !s_reg.run && s_reg.bcnt < BOOT_WORDS;
    endproperty
    a_byte_hold: assert property (p_byte_hold) else $error("ran before boot words loaded");

    property p_no_boot;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.boot == BOOT_RELEASE && s_reg.strap == STRAP_NO_BOOT && !bus_req
        |=> s_reg.run && s_reg.exec_ext && !s_reg.boot_go;
    endproperty
    a_no_boot: assert property (p_no_boot) else $error("no-boot start wrong");

    property p_host_hold;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.boot == BOOT_HOST_WAIT && !host_pm0_written |=> !s_reg.run;
    endproperty
    a_host_hold: assert property (p_host_hold) else $error("ran before word zero written");

    property p_int_one;
        @(posedge core_clk) disable iff (!reset_n)
        take_int |=> s_reg.done && (&s_reg.sel_n) ##1 !s_reg.done;
    endproperty
    a_int_one: assert property (p_int_one) else $error("internal access not one cycle");

    property p_ext_wait;
        @(posedge core_clk) disable iff (!reset_n)
        take_ext |=> s_reg.wcnt == $past(pick_wait) && s_reg.acc == ACC_EXT && !(&s_reg.sel_n);
    endproperty
    a_ext_wait: assert property (p_ext_wait) else $error("wait count not loaded");

    property p_ext_end;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.acc == ACC_EXT && s_reg.wcnt == 3'h0 |=> s_reg.done && (&s_reg.sel_n) && s_reg.cms_n;
    endproperty
    a_ext_end: assert property (p_ext_end) else $error("external access end wrong");

    property p_cms;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.cms_n == !(|(~s_reg.sel_n & s_reg.cs_en));
    endproperty
    a_cms: assert property (p_cms) else $error("composite select mismatch");

    property p_bus_req;
        @(posedge core_clk) disable iff (!reset_n)
        bus_req && s_reg.acc != ACC_EXT |=> (&s_reg.sel_n) && s_reg.cms_n && s_reg.grant;
    endproperty
    a_bus_req: assert property (p_bus_req) else $error("select during bus request");

    property p_bms_dis;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.bsd |-> s_reg.bms_n;
    endproperty
    a_bms_dis: assert property (p_bms_dis) else $error("boot select not disabled");

    property p_host_a0;
        @(posedge core_clk) disable iff (!reset_n)
        s_reg.strap[MODE_C_BIT] && s_reg.acc == ACC_EXT |-> s_reg.ext_addr[13:1] == 13'h0000;
    endproperty
    a_host_a0: assert property (p_host_a0) else $error("host mode drove upper address");

endmodule : mem_mode_decode

// [testbench/ext_bus_model.sv]
// far side model: strap driver, flag pin wire and boot byte memory
`timescale 1ns/10ps
module ext_bus_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // strap level and shared flag pin
    input wire logic strap_c,
    input wire logic flag_two_out,
    input wire logic flag_two_oe,
    output logic flag_two_in,
    // boot byte memory
    input wire logic boot_dma_start,
    output logic boot_word_loaded
);
    logic [6:0] words_left;
    // driver only in reset, afterwards the resistor holds the strap level while flag_two_oe is low
    assign flag_two_in = (!reset_n || !flag_two_oe) ? strap_c : flag_two_out;
    // one loaded word every other cycle after the start pulse
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            words_left <= 7'h00;
            boot_word_loaded <= 1'b0;
        end else if (boot_dma_start) begin
            words_left <= 7'h40;
            boot_word_loaded <= 1'b0;
        end else begin
            if (words_left != 7'h00) words_left <= words_left - 7'h01;
            boot_word_loaded <= words_left[0];
        end
    end
endmodule : ext_bus_model

// [testbench/memory_mode_and_external_decode_test.sv]
// self-checking bench for the memory mode and external decode block
`timescale 1ns/10ps
module memory_mode_and_external_decode_test;
    import mem_mode_pkg::*;
    logic core_clk = 0, reset_n = 0, strap_c = 0, mode_a_strap = 0, mode_b_strap = 0, host_pm0_written = 0;
    logic flag_two_in, flag_two_out, flag_two_oe, boot_word_loaded, boot_dma_start, core_run, exec_external;
    logic acc_req = 0, acc_fetch = 0, acc_done, acc_error, bus_req = 0, bus_grant, composite_select_n;
    logic program_memory_select_n, data_memory_select_n, boot_memory_select_n, io_space_select_n;
    logic [1:0] acc_space = 0, bresp, rresp;
    logic [13:0] acc_addr = 0, ext_addr, addr_seen;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic err_seen;
    int miscompares = 0, checks_done = 0, nsel, ncms, ncyc, n;
    logic [2:0] straps [4] = '{3'h5, 3'h4, 3'h2, 3'h0};
    logic [31:0] status_exp [4] = '{32'hB5, 32'h20B4, 32'h62, 32'h2020};
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
    // 100 MHz clock
    always #5 core_clk = ~core_clk;
    mem_mode_decode dut (.core_clk, .reset_n, .mode_a_strap, .mode_b_strap, .flag_two_in, .flag_two_out,
        .flag_two_oe, .boot_word_loaded, .host_pm0_written, .boot_dma_start, .core_run, .exec_external,
        .acc_req, .acc_space, .acc_fetch, .acc_addr, .acc_done, .acc_error, .bus_req, .bus_grant, .ext_addr,
        .program_memory_select_n, .data_memory_select_n, .boot_memory_select_n, .io_space_select_n,
        .composite_select_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
        .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
    ext_bus_model partner (.core_clk, .reset_n, .strap_c, .flag_two_out, .flag_two_oe, .flag_two_in,
        .boot_dma_start, .boot_word_loaded);
    task automatic print_verdict;
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {awaddr, wdata, wstrb} <= {a, d, 4'hF};
        {awvalid, wvalid, bready} <= 3'h7;
        for (n = 0; n < 60; n++) begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 60) begin miscompares++; print_verdict(); end
        `CHK(bresp, RESP_OKAY)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        for (n = 0; n < 60; n++) begin
            @(posedge core_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 60) begin miscompares++; print_verdict(); end
        `CHK({rresp, rdata}, {r, d})
    endtask : rd
    // one core access; counts select cycles and captures the bus address
    task automatic acc(input logic [1:0] s, input logic f, input logic [13:0] a);
        @(posedge core_clk);
        {acc_space, acc_fetch, acc_addr, acc_req} <= {s, f, a, 1'b1};
        nsel = 0;
        ncms = 0;
        for (n = 1; n < 60; n++) begin
            @(posedge core_clk);
            if (!(program_memory_select_n & data_memory_select_n & boot_memory_select_n & io_space_select_n)) begin
                nsel++;
                addr_seen = ext_addr;
            end
            if (composite_select_n === 1'b0) ncms++;
            if (acc_done) break;
        end
        acc_req <= 1'b0;
        {err_seen, ncyc} = {acc_error, n};
        if (n == 60) begin miscompares++; print_verdict(); end
    endtask : acc
    // ************************************************
    // scenarios
    // ************************************************
    initial begin
        for (int i = 0; i < 4; i++) begin
            {strap_c, mode_b_strap, mode_a_strap} <= straps[i];
            reset_n <= 1'b0;
            repeat (12) @(posedge core_clk);
            reset_n <= 1'b1;
            {mode_b_strap, mode_a_strap} <= ~straps[i][1:0];
            repeat (3) @(posedge core_clk);
            `CHK({core_run, exec_external}, {2{straps[i] == STRAP_NO_BOOT}})
            host_pm0_written <= 1'b1;
            @(posedge core_clk);
            host_pm0_written <= 1'b0;
            for (int k = 0; k < 200 && core_run !== 1'b1; k++) @(posedge core_clk);
            if (core_run !== 1'b1) begin miscompares++; print_verdict(); end
            rd(OFS_STATUS, status_exp[i], RESP_OKAY);
            if (i == 0) begin
                wr(OFS_OVERLAY, 32'h11);
                acc(SPACE_PROG, 1'b1, 14'h2000);
                `CHK({err_seen, nsel}, {1'b1, 32'd0})
                acc(SPACE_DATA, 1'b0, 14'h3FFF);
                `CHK({addr_seen, nsel}, {14'h0001, 32'd1})
            end
        end
        rd(OFS_OVERLAY, 32'h700, RESP_OKAY);
        rd(OFS_SEL_EN, 32'hB, RESP_OKAY);
        rd(8'h1A, 32'h0, RESP_SLVERR);
        wr(OFS_OVERLAY, 32'h112);
        acc(SPACE_DATA, 1'b0, 14'h2345);
        `CHK({addr_seen, nsel, ncms}, {14'h0345, 32'd2, 32'd2})
        acc(SPACE_PROG, 1'b1, 14'h2345);
        `CHK(addr_seen, 14'h2345)
        acc(SPACE_DATA, 1'b0, 14'h0010);
        `CHK({ncyc, nsel}, {32'd2, 32'd0})
        wr(OFS_IO_WAIT, 32'h3210);
        for (int r = 0; r < 4; r++) begin
            acc(SPACE_IO, 1'b0, 14'(14'h3805 + r * 512));
            `CHK({addr_seen, nsel, ncms}, {14'(r * 512 + 5), r + 1, r + 1})
        end
        wr(OFS_SEL_EN, 32'h2);
        acc(SPACE_IO, 1'b0, 14'h0001);
        `CHK({nsel, ncms}, {32'd1, 32'd0})
        acc(SPACE_BOOT, 1'b0, 14'h0004);
        `CHK({nsel, ncms, addr_seen}, {32'd1, 32'd0, 14'h0004})
        wr(OFS_SYS_CTRL, 32'h8);
        acc(SPACE_BOOT, 1'b0, 14'h0004);
        `CHK(nsel, 0)
        wr(OFS_FLAG, 32'h3);
        rd(OFS_STATUS, 32'h20A0, RESP_OKAY);
        bus_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        `CHK(bus_grant, 1'b1)
        print_verdict();
    end
endmodule : memory_mode_and_external_decode_test
